// file: hdl/gcr_defines.vh
// Constants for the global control register group.
// Included by gcr_global_regs.v and gcr_second_timer.v; definitions only.
`ifndef GCR_DEFINES_VH
`define GCR_DEFINES_VH
`define GCR_ADDR_W        11
`define GCR_ADDR_ID       11'h000
`define GCR_ADDR_ERRL     11'h023
`define GCR_ADDR_ERRH     11'h024
`define GCR_ADDR_RESET    11'h040
`define GCR_ADDR_GCONF    11'h041
`define GCR_ADDR_JCONF    11'h7E5
`define GCR_ADDR_PPL      11'h7E6
`define GCR_ADDR_PPH      11'h7E7
`define GCR_ADDR_NPL      11'h7E8
`define GCR_ADDR_NPH      11'h7E9
`define GCR_CHAN_LO       11'h001
`define GCR_CHAN_HI       11'h03F
// Arbitrary device code, not a real part's
`define GCR_ID_DEVICE     4'hA
`define GCR_ID_REV        4'h0
`define GCR_GCONF_RESET   8'h01
`define GCR_JCONF_RESET   3'h0
`define GCR_BIT_COPY      4
`define GCR_BIT_PIN1      3
`define GCR_BIT_PIN0      2
`define GCR_BIT_GLBIM     1
`define GCR_BIT_TMRIM     0
`define GCR_BIT_JHALT     2
`define GCR_BIT_JMETHOD   1
`define GCR_BIT_JBW       0
`define GCR_RESET_NS      1000
`define GCR_CLK_MHZ       25
`define GCR_SECOND_CYC    25000000
`endif

// file: hdl/gcr_global_regs.v
// Global register group of a multi-channel line interface unit.
// Assumes a host port with one-cycle strobes and read data one cycle later.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "gcr_defines.vh"
module gcr_global_regs #(
  parameter NUM_CHAN   = 17,
  parameter SECOND_CYC = `GCR_SECOND_CYC,
  parameter DEVICE_ID  = `GCR_ID_DEVICE,
  parameter REVISION   = `GCR_ID_REV
) (
  // Clock and reset
  input  wire                   clock,
  input  wire                   rstn,
  // Host register port
  input  wire [`GCR_ADDR_W-1:0] hostAddr,
  input  wire [7:0]             hostWrData,
  input  wire                   hostWrStb,
  input  wire                   hostRdStb,
  input  wire [3:0]             hostChan,
  output reg  [7:0]             hostRdData_ff,
  // Per-channel register write fan-out
  output reg  [NUM_CHAN-1:0]    chanWrEn_ff,
  output reg  [`GCR_ADDR_W-1:0] chanWrAddr_ff,
  output reg  [7:0]             chanWrData_ff,
  // Per-channel interrupt sources
  input  wire [NUM_CHAN-1:0]    chanIrqPend,
  // Error counter source
  input  wire [15:0]            errorTally,
  // Channel 0 jitter measurement
  input  wire [11:0]            positivePeakValue,
  input  wire [11:0]            negativePeakValue,
  output reg                    jitterHalt_ff,
  output reg                    jitterMethod_ff,
  output reg                    jitterBandwidth_ff,
  // Software reset to the rest of the device
  output reg                    softReset_ff,
  // Interrupt pin, open-drain capable
  output reg                    irqOut_ff,
  output reg                    irqOe_n_ff
);
  localparam integer RESET_CYC_RAW = (`GCR_RESET_NS * `GCR_CLK_MHZ) / 1000;
  localparam integer RESET_CYC = (RESET_CYC_RAW < 1) ? 1 : RESET_CYC_RAW;
  localparam ST_IDLE  = 1'b0;
  localparam ST_RESET = 1'b1;

  reg  [7:0]  gconf_ff;
  reg  [15:0] resetCnt_ff;
  reg         state_ff;
  wire        tick;
  wire        anyChanIrq;
  wire        irqActive;
  wire        chanHit;
  reg  [7:0]  nxt_rdData;

  function automatic isChanAddr;
    input [`GCR_ADDR_W-1:0] a;
    begin
      isChanAddr = (a >= `GCR_CHAN_LO) && (a <= `GCR_CHAN_HI);
    end
  endfunction

  gcr_second_timer #(
    .SECOND_CYC (SECOND_CYC)
  ) uTimer (
    .clock     (clock),
    .rstn      (rstn),
    .softReset (softReset_ff),
    .tick_ff   (tick)
  );

  assign chanHit    = hostWrStb && isChanAddr(hostAddr) && (state_ff == ST_IDLE);
  assign anyChanIrq = |chanIrqPend && !gconf_ff[`GCR_BIT_GLBIM];
  assign irqActive  = anyChanIrq || (tick && !gconf_ff[`GCR_BIT_TMRIM]);

  // Software reset sequencer; host writes are ignored while it runs
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff     <= ST_IDLE;
      resetCnt_ff  <= 16'h0000;
      softReset_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (hostWrStb && hostAddr == `GCR_ADDR_RESET) begin
            state_ff     <= ST_RESET;
            resetCnt_ff  <= RESET_CYC[15:0] - 16'h0001;
            softReset_ff <= 1'b1;
          end
        end
        ST_RESET: begin
          if (resetCnt_ff == 16'h0000) begin
            state_ff     <= ST_IDLE;
            softReset_ff <= 1'b0;
          end else begin
            resetCnt_ff <= resetCnt_ff - 16'h0001;
          end
        end
        default: begin
          state_ff     <= ST_IDLE;
          softReset_ff <= 1'b0;
        end
      endcase
    end
  end

  // Writable registers, restored to defaults by the software reset
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gconf_ff           <= `GCR_GCONF_RESET;
      jitterHalt_ff      <= 1'b0;
      jitterMethod_ff    <= 1'b0;
      jitterBandwidth_ff <= 1'b0;
    end else if (softReset_ff) begin
      gconf_ff           <= `GCR_GCONF_RESET;
      jitterHalt_ff      <= 1'b0;
      jitterMethod_ff    <= 1'b0;
      jitterBandwidth_ff <= 1'b0;
    end else if (hostWrStb) begin
      if (hostAddr == `GCR_ADDR_GCONF)
        gconf_ff <= {3'h0, hostWrData[4:0]};
      if (hostAddr == `GCR_ADDR_JCONF) begin
        jitterHalt_ff      <= hostWrData[`GCR_BIT_JHALT];
        jitterMethod_ff    <= hostWrData[`GCR_BIT_JMETHOD];
        jitterBandwidth_ff <= hostWrData[`GCR_BIT_JBW];
      end
    end
  end

  // Per-channel write fan-out; copy mode hits every channel at once
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch = ch + 1) begin : gChan
      always @(posedge clock or negedge rstn) begin
        if (!rstn)
          chanWrEn_ff[ch] <= 1'b0;
        else
          chanWrEn_ff[ch] <= chanHit && (gconf_ff[`GCR_BIT_COPY] || hostChan == ch);
      end
    end
  endgenerate

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      chanWrAddr_ff <= {`GCR_ADDR_W{1'b0}};
      chanWrData_ff <= 8'h00;
    end else if (chanHit) begin
      chanWrAddr_ff <= hostAddr;
      chanWrData_ff <= hostWrData;
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    nxt_rdData = 8'h00;
    case (hostAddr)
      `GCR_ADDR_ID:    nxt_rdData = {DEVICE_ID[3:0], REVISION[3:0]};
      `GCR_ADDR_ERRL:  nxt_rdData = errorTally[7:0];
      `GCR_ADDR_ERRH:  nxt_rdData = errorTally[15:8];
      `GCR_ADDR_GCONF: nxt_rdData = gconf_ff;
      `GCR_ADDR_JCONF: nxt_rdData = {5'h00, jitterHalt_ff, jitterMethod_ff, jitterBandwidth_ff};
      `GCR_ADDR_PPL:   nxt_rdData = positivePeakValue[7:0];
      `GCR_ADDR_PPH:   nxt_rdData = {4'h0, positivePeakValue[11:8]};
      `GCR_ADDR_NPL:   nxt_rdData = negativePeakValue[7:0];
      `GCR_ADDR_NPH:   nxt_rdData = {4'h0, negativePeakValue[11:8]};
      default:         nxt_rdData = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      hostRdData_ff <= 8'h00;
    else if (hostRdStb)
      hostRdData_ff <= nxt_rdData;
    else
      hostRdData_ff <= 8'h00;
  end

  // Pin style: open drain drives low only when active, else floats
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irqOut_ff  <= 1'b1;
      irqOe_n_ff <= 1'b1;
    end else if (!gconf_ff[`GCR_BIT_PIN0]) begin
      irqOut_ff  <= 1'b0;
      irqOe_n_ff <= !irqActive;
    end else begin
      irqOut_ff  <= gconf_ff[`GCR_BIT_PIN1] ? irqActive : !irqActive;
      irqOe_n_ff <= 1'b0;
    end
  end
endmodule

// file: hdl/gcr_second_timer.v
// One-second tick generator locked to the master clock.
// Assumes a free-running clock at the rate given by the defines header.
`timescale 1ns/100ps
`include "gcr_defines.vh"
module gcr_second_timer #(
  parameter SECOND_CYC = `GCR_SECOND_CYC
) (
  // Clock and reset
  input  wire clock,
  input  wire rstn,
  input  wire softReset,
  // Tick
  output reg  tick_ff
);
  reg  [31:0] count_ff;
  wire        wrap = (count_ff == SECOND_CYC - 1);
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_ff <= 32'h00000000;
      tick_ff  <= 1'b0;
    end else if (softReset) begin
      count_ff <= 32'h00000000;
      tick_ff  <= 1'b0;
    end else begin
      count_ff <= wrap ? 32'h00000000 : count_ff + 32'h00000001;
      tick_ff  <= wrap;
    end
  end
endmodule

// file: testbench/gcr_global_regs_chk.sv
// Port assertions for the global register group.
// Assumes the plain strobed port timing; bound to every instance below.
`timescale 1ns/100ps
module gcr_global_regs_chk #(
  parameter NUM_CHAN = 17
) (
  input wire                clock,
  input wire                rstn,
  input wire [10:0]         hostAddr,
  input wire [7:0]          hostWrData,
  input wire                hostWrStb,
  input wire                hostRdStb,
  input wire [7:0]          hostRdData_ff,
  input wire [NUM_CHAN-1:0] chanWrEn_ff,
  input wire [7:0]          chanWrData_ff,
  input wire [15:0]         errorTally,
  input wire [11:0]         positivePeakValue,
  input wire [11:0]         negativePeakValue,
  input wire                jitterHalt_ff,
  input wire                jitterMethod_ff,
  input wire                jitterBandwidth_ff,
  input wire                softReset_ff
);
  reg [39:0] snap_ff;
  wire       rdGo = hostRdStb;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Sources are read live at the strobe edge
  always @(posedge clock) snap_ff <= {errorTally, positivePeakValue, negativePeakValue};
  chk_soft_start: assert property (hostWrStb && hostAddr == 11'h040 && !softReset_ff |=> softReset_ff)
    else $error("soft reset did not start");
  chk_soft_end: assert property ($rose(softReset_ff) |-> ##[1:25] !softReset_ff)
    else $error("soft reset too long");
  chk_id_rev: assert property (rdGo && hostAddr == 11'h000 |=> hostRdData_ff[3:0] == 4'h0)
    else $error("revision wrong");
  chk_err_low: assert property (rdGo && hostAddr == 11'h023 |=> hostRdData_ff == snap_ff[31:24])
    else $error("error tally low wrong");
  chk_err_high: assert property (rdGo && hostAddr == 11'h024 |=> hostRdData_ff == snap_ff[39:32])
    else $error("error tally high wrong");
  chk_pos_high: assert property (rdGo && hostAddr == 11'h7E7 |=> hostRdData_ff == {4'h0, snap_ff[23:20]})
    else $error("positive peak high wrong");
  chk_neg_low: assert property (rdGo && hostAddr == 11'h7E8 |=> hostRdData_ff == snap_ff[7:0])
    else $error("negative peak low wrong");
  chk_chan_fan: assert property (hostWrStb && hostAddr inside {[11'h001:11'h03F]} && !softReset_ff
    |=> chanWrEn_ff != 0 && chanWrData_ff == $past(hostWrData))
    else $error("channel write lost");
  chk_jit_cfg: assert property (hostWrStb && hostAddr == 11'h7E5 && !softReset_ff
    |=> {jitterHalt_ff, jitterMethod_ff, jitterBandwidth_ff} == $past(hostWrData[2:0]))
    else $error("jitter config wrong");
endmodule
bind gcr_global_regs gcr_global_regs_chk #(.NUM_CHAN(NUM_CHAN)) i_chk (
  .clock(clock), .rstn(rstn), .hostAddr(hostAddr), .hostWrData(hostWrData),
  .hostWrStb(hostWrStb), .hostRdStb(hostRdStb), .hostRdData_ff(hostRdData_ff),
  .chanWrEn_ff(chanWrEn_ff), .chanWrData_ff(chanWrData_ff), .errorTally(errorTally),
  .positivePeakValue(positivePeakValue), .negativePeakValue(negativePeakValue),
  .jitterHalt_ff(jitterHalt_ff), .jitterMethod_ff(jitterMethod_ff),
  .jitterBandwidth_ff(jitterBandwidth_ff), .softReset_ff(softReset_ff));

// file: testbench/gcr_global_regs_tb.sv
// Self-checking bench for the global register group.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/100ps
module gcr_global_regs_tb;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [16:0] chanIrqPend = '0;
  logic [15:0] errorTally = '0;
  logic [11:0] positivePeakValue = '0;
  logic [11:0] negativePeakValue = '0;
  logic        rdLast = 1'b0;
  logic [7:0]  d;
  logic [7:0]  sty[4] = '{8'h00, 8'h04, 8'h0C, 8'h08};
  wire  [10:0] chanWrAddr_ff;
  wire  [10:0] hostAddr;
  wire  [7:0]  hostWrData, hostRdData_ff, chanWrData_ff;
  wire  [3:0]  hostChan;
  wire  [16:0] chanWrEn_ff;
  wire         hostWrStb, hostRdStb, softReset_ff, irqOut_ff, irqOe_n_ff;
  integer      seed = 70, fail_count = 0, tests_run = 0, i;
  always #20 clock = ~clock;
  gcr_host_model i_host (.clock(clock), .hostAddr(hostAddr), .hostWrData(hostWrData),
    .hostWrStb(hostWrStb), .hostRdStb(hostRdStb), .hostChan(hostChan));
  // Device code 5 is arbitrary
  gcr_global_regs #(.SECOND_CYC(100), .DEVICE_ID(4'h5)) i_dut (.clock(clock), .rstn(rstn),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWrStb(hostWrStb), .hostRdStb(hostRdStb),
    .hostChan(hostChan), .hostRdData_ff(hostRdData_ff), .chanWrEn_ff(chanWrEn_ff),
    .chanWrAddr_ff(chanWrAddr_ff), .chanWrData_ff(chanWrData_ff), .chanIrqPend(chanIrqPend),
    .errorTally(errorTally), .positivePeakValue(positivePeakValue),
    .negativePeakValue(negativePeakValue), .jitterHalt_ff(), .jitterMethod_ff(),
    .jitterBandwidth_ff(), .softReset_ff(softReset_ff), .irqOut_ff(irqOut_ff),
    .irqOe_n_ff(irqOe_n_ff));
  task automatic chk(input string n, input logic [16:0] s, input logic [16:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock) rdLast <= hostRdStb;
  always @(negedge clock) if (rdLast) chk("rdData", hostRdData_ff, i_host.expQ.pop_front());
  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    errorTally <= $random(seed);
    positivePeakValue <= $random(seed);
    negativePeakValue <= $random(seed);
    i_host.rd(11'h000, 8'h50);
    i_host.rd(11'h041, 8'h01);
    i_host.rd(11'h023, errorTally[7:0]);
    i_host.rd(11'h024, errorTally[15:8]);
    i_host.rd(11'h7E6, positivePeakValue[7:0]);
    i_host.rd(11'h7E7, {4'h0, positivePeakValue[11:8]});
    i_host.rd(11'h7E8, negativePeakValue[7:0]);
    i_host.rd(11'h7E9, {4'h0, negativePeakValue[11:8]});
    i_host.rd(11'h100, 8'h00);
    i_host.wr(11'h000, 8'hFF);
    i_host.rd(11'h000, 8'h50);
    d = $random(seed);
    i_host.wr(11'h7E5, d);
    i_host.rd(11'h7E5, {5'h0, d[2:0]});
    for (i = 0; i < 2; i++) begin
      d = $random(seed);
      i_host.wr(11'h041, {3'h0, i[0], 4'h1});
      i_host.wr(11'h03F, d, 4'h6);
      @(negedge clock);
      chk("chanWrEn", chanWrEn_ff, i ? 17'h1FFFF : 17'h00040);
      chk("chanWrData", chanWrData_ff, d);
      chk("chanWrAddr", chanWrAddr_ff, 11'h03F);
    end
    @(posedge clock);
    chanIrqPend <= 17'h10000;
    for (i = 0; i < 4; i++) begin
      i_host.wr(11'h041, sty[i]);
      repeat (2) @(negedge clock);
      chk("irqOut", irqOut_ff, i == 2);
      chk("irqOe_n", irqOe_n_ff, 1'b0);
    end
    i_host.wr(11'h041, 8'h03);
    repeat (2) @(negedge clock);
    chk("irqMasked", irqOe_n_ff, 1'b1);
    i_host.wr(11'h041, 8'h02);
    for (i = 0; i < 110 && irqOe_n_ff !== 1'b0; i++) @(negedge clock);
    chk("tickSeen", i < 110, 1'b1);
    @(negedge clock);
    chk("tickPulse", irqOe_n_ff, 1'b1);
    i_host.wr(11'h041, 8'hFF);
    i_host.rd(11'h041, 8'h1F);
    i_host.wr(11'h040, $random(seed));
    i_host.rd(11'h041, 8'h01);
    chk("softReset", softReset_ff, 1'b0);
    repeat (3) @(posedge clock);
    tally_and_finish;
  end
endmodule

// file: testbench/gcr_host_model.sv
// Host processor model for the register port.
// Assumes the bench calls its tasks; expected read data go on expQ.
`timescale 1ns/100ps
module gcr_host_model (
  input  wire         clock,
  output logic [10:0] hostAddr,
  output logic [7:0]  hostWrData,
  output logic        hostWrStb,
  output logic        hostRdStb,
  output logic [3:0]  hostChan
);
  logic [7:0] expQ[$];
  initial {hostAddr, hostWrData, hostWrStb, hostRdStb, hostChan} = '0;
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic [3:0] c = 4'h0);
    @(posedge clock);
    hostAddr <= a;
    hostWrData <= d;
    hostChan <= c;
    hostWrStb <= 1'b1;
    @(posedge clock);
    hostWrStb <= 1'b0;
    // Device is unusable while its own reset runs
    if (a == 11'h040) repeat (25) @(posedge clock);
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(posedge clock);
    hostAddr <= a;
    hostRdStb <= 1'b1;
    expQ.push_back(e);
    @(posedge clock);
    hostRdStb <= 1'b0;
  endtask
endmodule
